//--- logic/dpa_output.sv
// Clock phases, stage delay line, correction and output register for both channels
//
// Overview of operation
// - Two independent 8-bit channels, own outputs
// - Non-overlapping sample and hold phases
// - Stages sample one phase, amplify other
// - Alternate stages use opposite phases
// - Six redundant 2-bit stages, final flash
// - Delay line aligns stage codes per sample
// - Overlap add corrects into 8-bit word
// - Result appears eight samples after the codes change
// - One new result every sample period
// - Flag first 20 samples invalid
// - Offset binary, msb in bit 7
// - All ones top, all zeros bottom
`default_nettype none
`include "dpa_params.svh"

module dpa_output
	import dpa_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire dpa_chan_codes_t stage_codes,
	output logic phase_sample,
	output logic phase_hold,
	output logic sample_tick,
	output dpa_chan_result_t chan_result,
	output logic result_valid
);

	// Overlap add: stage k weighs 2^(6-k); the sum can pass full scale
	function automatic logic [`DPA_RESULT_BITS-1:0] dpa_correct(input dpa_stage_codes_t c);
		logic [9:0] sum;
		sum = 10'h000;
		for (int k = 0; k < `DPA_STAGES; k++) begin
			sum = sum + (10'(c.stage[k]) << (`DPA_STAGES - 1 - k));
		end
		// No floor clamp: stage codes only ever add
		// Clamp keeps over-range at all ones instead of wrapping
		dpa_correct = (sum > 10'h0FF) ? 8'hFF : sum[7:0];
	endfunction : dpa_correct

	// Three-flop filter: a bit moves only when stages two and three agree
	function automatic dpa_chan_codes_t dpa_agree(input dpa_chan_codes_t a, input dpa_chan_codes_t b,
		input dpa_chan_codes_t held);
		dpa_agree = (a & b) | (held & (a | b));
	endfunction : dpa_agree

	logic rst_s1_q;
	logic rst_n_q;
	logic [1:0] ph_q;
	dpa_chan_codes_t sync1_q;
	dpa_chan_codes_t sync2_q;
	dpa_chan_codes_t sync3_q;
	dpa_chan_codes_t codes_q;
	dpa_code_t dl_q [2][`DPA_STAGES][`DPA_DELAY_DEPTH];
	dpa_chan_result_t pipe_q [2];
	logic [`DPA_LATENCY_CYCLES-1:0] fill_q;
	logic [`DPA_INVALID_CNT_W-1:0] inv_cnt_q;
	logic phase_sample_q;
	logic phase_hold_q;
	logic sample_tick_q;
	dpa_chan_result_t chan_result_q;
	logic result_valid_q;

	wire logic sample_en;
	wire logic half_en;
	wire dpa_code_t [`DPA_STAGES-1:0] cap_code [2];
	wire dpa_stage_codes_t aligned [2];
	wire dpa_chan_result_t corrected;
	wire logic warmed;
	wire logic [1:0] ph_next;
	wire logic ps_next;
	wire logic hold_next;
	wire logic fill_done;
	wire logic [`DPA_INVALID_CNT_W-1:0] inv_cnt_d;
	wire dpa_chan_result_t out_next;

	// Assertion stays asynchronous, release is synchronous
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	assign sample_en = (ph_q == `DPA_PH_SAMPLE);
	assign half_en = (ph_q == `DPA_PH_SAMPLE) || (ph_q == `DPA_PH_HOLD);
	// Registered phases decode the next count so they line up with it
	assign ph_next = ph_q + 2'h1;
	assign ps_next = (ph_next == `DPA_PH_SAMPLE);
	assign hold_next = (ph_next == `DPA_PH_HOLD);

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ph_q <= 2'h3;
			phase_sample_q <= 1'b0;
			phase_hold_q <= 1'b0;
			sample_tick_q <= 1'b0;
		end else begin
			ph_q <= ph_next;
			phase_sample_q <= ps_next;
			phase_hold_q <= hold_next;
			sample_tick_q <= sample_en;
		end
	end

	// Stage codes come from comparators outside this clock
	// Zero codes in reset so early words read as zero
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			codes_q <= '0;
		end else begin
			sync1_q <= stage_codes;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			codes_q <= dpa_agree(sync2_q, sync3_q, codes_q);
		end
	end

	assign cap_code[0] = codes_q.inphase.stage;
	assign cap_code[1] = codes_q.quad.stage;

	// Depth eight lets stage zero wait seven half periods
	// shift every half period
	// stage k settles k half periods after the sample
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < 2; c++) begin
				for (int k = 0; k < `DPA_STAGES; k++) begin
					for (int j = 0; j < `DPA_DELAY_DEPTH; j++) begin
						dl_q[c][k][j] <= 2'h0;
					end
				end
			end
		end else if (half_en) begin
			for (int c = 0; c < 2; c++) begin
				for (int k = 0; k < `DPA_STAGES; k++) begin
					dl_q[c][k][0] <= cap_code[c][k];
					for (int j = 1; j < `DPA_DELAY_DEPTH; j++) begin
						dl_q[c][k][j] <= dl_q[c][k][j-1];
					end
				end
			end
		end
	end

	// stage k read at tap 7-k
	genvar gc, gk;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_chan
			for (gk = 0; gk < `DPA_STAGES; gk++) begin : g_stage
				assign aligned[gc].stage[gk] = dl_q[gc][gk][`DPA_DELAY_DEPTH - 1 - gk];
			end
		end
	endgenerate

	assign corrected.inphase = dpa_correct(aligned[0]);
	assign corrected.quad = dpa_correct(aligned[1]);

	// Last pipe stage feeds the output register
	assign out_next = pipe_q[1];

	// two pipe stages plus output register
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pipe_q[0] <= '0;
			pipe_q[1] <= '0;
			chan_result_q <= '0;
		end else if (sample_en) begin
			pipe_q[0] <= corrected;
			pipe_q[1] <= pipe_q[0];
			chan_result_q <= out_next;
		end
	end

	// words before the pipeline fills and warm-up ends are flagged
	assign warmed = (inv_cnt_q == 5'(`DPA_INVALID_CYCLES));
	assign fill_done = fill_q[`DPA_LATENCY_CYCLES-2];
	// Counter stops at the limit so it cannot wrap back to invalid
	assign inv_cnt_d = inv_cnt_q + 5'h01;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fill_q <= '0;
			inv_cnt_q <= '0;
			result_valid_q <= 1'b0;
		end else if (sample_en) begin
			fill_q <= {fill_q[`DPA_LATENCY_CYCLES-2:0], 1'b1};
			if (!warmed) begin
				inv_cnt_q <= inv_cnt_d;
			end
			result_valid_q <= warmed && fill_done;
		end
	end

	assign phase_sample = phase_sample_q;
	assign phase_hold = phase_hold_q;
	assign sample_tick = sample_tick_q;
	assign chan_result = chan_result_q;
	assign result_valid = result_valid_q;

endmodule : dpa_output

`default_nettype wire

//--- logic/dpa_params.svh
// Timing and format constants for the dual pipelined converter output logic
`ifndef DPA_PARAMS_SVH
`define DPA_PARAMS_SVH

`define DPA_CLK_PERIOD_NS 10
// Clock cycles per sample period; phases take one cycle each with a gap between
`define DPA_SAMPLE_DIV 4
`define DPA_PH_SAMPLE 2'h0
`define DPA_PH_HOLD 2'h2
`define DPA_MIN_RATE_SPS 1000000
`define DPA_RESULT_BITS 8
`define DPA_STAGES 7
`define DPA_DELAY_DEPTH 8
`define DPA_LATENCY_CYCLES 6
`define DPA_INVALID_CYCLES 20
`define DPA_INVALID_CNT_W 5

`endif

//--- logic/dpa_pkg.sv
// Types shared by the dual pipelined converter output logic
`default_nettype none
`include "dpa_params.svh"

package dpa_pkg;

	typedef logic [1:0] dpa_code_t;

	// Stage 0..5 carry a redundant bit; stage 6 is the final flash
	typedef struct packed {
		dpa_code_t [`DPA_STAGES-1:0] stage;
	} dpa_stage_codes_t;

	typedef struct packed {
		dpa_stage_codes_t inphase;
		dpa_stage_codes_t quad;
	} dpa_chan_codes_t;

	typedef struct packed {
		logic [`DPA_RESULT_BITS-1:0] inphase;
		logic [`DPA_RESULT_BITS-1:0] quad;
	} dpa_chan_result_t;

endpackage : dpa_pkg

`default_nettype wire

//--- verification/dpa_capture.sv
// Downstream capture of both result words
`default_nettype none
module dpa_capture
	import dpa_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sample_tick,
	input wire logic result_valid,
	input wire dpa_chan_result_t chan_result,
	output dpa_chan_result_t word_q,
	output logic [7:0] cnt_q
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) begin
			word_q <= '0;
			cnt_q <= 8'h00;
		end else if (sample_tick && result_valid) begin
			word_q <= chan_result;
			cnt_q <= cnt_q + 8'h01;
		end
endmodule : dpa_capture
`default_nettype wire

//--- verification/dpa_output_bench.sv
// Bench for the dual converter output logic
`default_nettype none
module dpa_output_bench;
	import dpa_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic arst_n = 0;
	dpa_chan_codes_t codes = '0;
	logic ps, ph, tk, rv;
	logic [7:0] cnt;
	dpa_chan_result_t res, cap;
	int failures = 0, n_tests = 0, cyc = 0;
	logic [13:0] cv[4] = '{14'h0000, 14'h3FFF, 14'h0002, 14'h1555};
	logic [7:0] ev[4] = '{8'h00, 8'hFF, 8'h80, 8'h7F};
	dpa_output u_dut(.clk(clk), .arst_n(arst_n), .stage_codes(codes), .phase_sample(ps),
		.phase_hold(ph), .sample_tick(tk), .chan_result(res), .result_valid(rv));
	dpa_capture u_cap(.clk(clk), .arst_n(arst_n), .sample_tick(tk), .result_valid(rv),
		.chan_result(res), .word_q(cap), .cnt_q(cnt));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			conclude();
		end
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task ticks(input int n);
		repeat (n) @(posedge tk);
		@(negedge clk);
	endtask : ticks
	task t_warm;
		int n;
		n = 0;
		arst_n = 0;
		repeat (4) @(negedge clk);
		chk(res, 16'h0000);
		chk(rv, 16'h0000);
		arst_n = 1;
		while (rv !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(cnt, 16'h0000);
		chk(n <= 100, 16'h0001);
		$display("warm-up done");
	endtask : t_warm
	task t_code;
		int i, p;
		for (int k = 0; k < 5; k++) begin
			i = k % 4;
			p = (k + 3) % 4;
			codes = {cv[i], cv[(i + 2) % 4]};
			ticks(2);
			// Old word must outlast the pipeline
			if (k > 0) chk(cap, {ev[p], ev[(p + 2) % 4]});
			ticks(11);
			chk(cap, {ev[i], ev[(i + 2) % 4]});
		end
		$display("codes done");
	endtask : t_code
	task conclude;
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		@(negedge clk);
		t_warm();
		t_code();
		t_warm();
		conclude();
	end
endmodule : dpa_output_bench
`default_nettype wire

//--- verification/dpa_output_sva.sv
// Port assertions for the converter output logic
`default_nettype none
module dpa_output_sva
	import dpa_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic phase_sample,
	input wire logic phase_hold,
	input wire logic sample_tick,
	input wire dpa_chan_result_t chan_result,
	input wire logic result_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// Saturates so the bound fires once and never wraps back to it
	logic [4:0] tick_q;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) tick_q <= 5'h00;
		else if (phase_sample && tick_q != 5'h1F) tick_q <= tick_q + 5'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_next4(s);
		!s [*3] ##1 s;
	endsequence
	a_phase_apart: assert property (!(phase_sample && phase_hold))
		else $error("phases overlap");
	a_gap_hold: assert property (phase_sample |=> !phase_hold ##1 phase_hold)
		else $error("hold phase misplaced");
	a_sample_rate: assert property (phase_sample |=> s_next4(phase_sample))
		else $error("sample period wrong");
	a_hold_rate: assert property (phase_hold |=> s_next4(phase_hold))
		else $error("hold period wrong");
	a_tick_rate: assert property (sample_tick |=> s_next4(sample_tick))
		else $error("tick period wrong");
	a_word_stands: assert property ($changed(chan_result) |=> $stable(chan_result) [*3])
		else $error("word changed early");
	a_valid_holds: assert property (result_valid |=> result_valid)
		else $error("valid dropped");
	a_valid_bound: assert property (tick_q == 5'h19 |-> result_valid)
		else $error("valid late");
endmodule : dpa_output_sva
bind dpa_output dpa_output_sva u_sva(.clk(clk), .arst_n(arst_n), .phase_sample(phase_sample),
	.phase_hold(phase_hold), .sample_tick(sample_tick), .chan_result(chan_result),
	.result_valid(result_valid));
`default_nettype wire
